// File: pkg/stkg_defines.vh
// Register offsets, field positions, reset values and timing constants for the sidetone/keyclick block.
`ifndef STKG_DEFINES_VH
`define STKG_DEFINES_VH
// Register offsets (page-local addresses).
`define STKG_ADDR_SIDETONE 6'h03
`define STKG_ADDR_CLICK 6'h04
// Sidetone register fields.
`define STKG_AST_MUTE_BIT 15
`define STKG_AST_GAIN_HI 14
`define STKG_AST_GAIN_LO 8
`define STKG_DST_MUTE_BIT 7
`define STKG_DST_GAIN_HI 6
`define STKG_DST_GAIN_LO 1
`define STKG_AST_FLAG_BIT 0
`define STKG_AST_GAIN_RST 7'h45
`define STKG_AST_GAIN_MAX 7'h5d
`define STKG_DST_GAIN_RST 6'h00
// Keyclick / soft-step register fields.
`define STKG_CLK_EN_BIT 15
`define STKG_CLK_AMP_HI 14
`define STKG_CLK_AMP_LO 12
`define STKG_ADC_STEP_BIT 11
`define STKG_CLK_FRQ_HI 10
`define STKG_CLK_FRQ_LO 8
`define STKG_CLK_LEN_HI 7
`define STKG_CLK_LEN_LO 4
`define STKG_DACL_FLAG_BIT 3
`define STKG_DACR_FLAG_BIT 2
`define STKG_DAC_STEP_BIT 1
`define STKG_ADC_FLAG_BIT 0
`define STKG_CLK_AMP_RST 3'h4
`define STKG_CLK_FRQ_RST 3'h4
`define STKG_CLK_LEN_RST 4'h1
// Keyclick tone timing: half period of the 8 kHz tone in ns, scaled by code.
`define STKG_CLK_TOP_HALF_NS 62500
`define STKG_CLK_PERIOD_NS 8
`define STKG_CLK_FRQ_TOP 3'h7
`endif

// File: hdl/stkg_sync.v
// Two-flop synchroniser for a single asynchronous level.
`timescale 1ns/100ps
`default_nettype none
module stkg_sync (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Asynchronous level in, synchronised level out.
    input wire d,
    output wire q
);
    reg meta_r;
    reg sync_r;

    // The first stage is read only by the second stage.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule // stkg_sync
`default_nettype wire

// File: hdl/stkg_stepper.v
// Soft-stepping gain follower paced by a word-clock tick.
`timescale 1ns/100ps
`default_nettype none
module stkg_stepper #(
    parameter W = 7
) (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Word-clock tick (one-cycle pulse) and rate select.
    input wire tick,
    input wire slow,
    // Target and applied gain.
    input wire [W-1:0] target,
    output reg [W-1:0] applied,
    output wire reached
);
    reg skip_r;

    // One code (0.5 dB) per tick, or per two ticks when slow is set.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied <= {W{1'b0}};
            skip_r <= 1'b0;
        end else if (tick) begin
            skip_r <= slow ? ~skip_r : 1'b0;
            if (!(slow && !skip_r) && applied != target) begin
                if (applied < target) begin
                    applied <= applied + {{(W-1){1'b0}}, 1'b1};
                end else begin
                    applied <= applied - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Drops the cycle a differing target appears, returns on arrival.
    assign reached = (applied == target);
endmodule // stkg_stepper
`default_nettype wire

// File: hdl/stkg_regs.v
// Sidetone gain/mute and keyclick/soft-step control registers with status flags.
`timescale 1ns/100ps
`default_nettype none
`include "stkg_defines.vh"
module stkg_regs #(
    parameter AW = 6,
    parameter ADC_GW = 7,
    parameter DAC_GW = 7
) (
    // Clock and asynchronous reset.
    input wire clk,
    input wire arst_n,
    // Register port from the serial control interface.
    input wire [AW-1:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    // Word clocks from the audio pins.
    input wire adc_word_select,
    input wire dac_word_clock,
    // Sidetone zero-crossing detector, asynchronous level.
    input wire sidetone_zero_cross,
    // Gain targets and auto gain status from the codec registers/loop.
    input wire auto_gain_enable,
    input wire [ADC_GW-1:0] adc_gain_target,
    input wire [DAC_GW-1:0] dac_left_target,
    input wire [DAC_GW-1:0] dac_right_target,
    input wire agc_below_noise,
    input wire agc_saturated,
    // Sidetone controls to the analog and digital paths.
    output reg analog_sidetone_mute,
    output reg [6:0] analog_sidetone_gain,
    output reg digital_sidetone_mute,
    output reg [5:0] digital_sidetone_gain,
    // Soft-stepped applied gains.
    output wire [ADC_GW-1:0] adc_gain_applied,
    output wire [DAC_GW-1:0] dac_left_applied,
    output wire [DAC_GW-1:0] dac_right_applied,
    // Keyclick tone output and amplitude code.
    output reg click_tone,
    output reg click_active,
    output reg [2:0] click_amplitude
);
    // Tone half period in cycles for the top code, rounded to the nearest cycle.
    // Each lower code doubles it, so the slowest tone needs a twenty-bit counter.
    localparam integer HALF_TOP = (`STKG_CLK_TOP_HALF_NS + `STKG_CLK_PERIOD_NS / 2)
                                  / `STKG_CLK_PERIOD_NS;
    localparam integer HCW = 20;

    // Saturating decode of the analog gain code.
    function [6:0] ast_sat;
        input [6:0] code;
        begin
            ast_sat = (code > `STKG_AST_GAIN_MAX) ? `STKG_AST_GAIN_MAX : code;
        end
    endfunction

    // Reset release and pin synchronisers.
    reg rst_meta_r;
    reg rst_n_r;
    wire rst_n;
    wire adc_word_select_s;
    wire dac_word_clock_s;
    wire zc_s;
    reg adc_word_select_d_r;
    reg dac_word_clock_d_r;
    reg zc_d_r;
    wire adc_tick;
    wire dac_tick;
    wire zc_tick;

    // Reset is released through two flops so every register leaves reset on
    // the same edge; the pin synchronisers sit in reset too, so a word clock
    // that toggles during reset cannot leave a false tick behind.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_n_r;

    stkg_sync u_sync_adc_word_select (.clk(clk), .rst_n(rst_n), .d(adc_word_select), .q(adc_word_select_s));
    stkg_sync u_sync_dac_word_clock (.clk(clk), .rst_n(rst_n), .d(dac_word_clock), .q(dac_word_clock_s));
    stkg_sync u_sync_zc (.clk(clk), .rst_n(rst_n), .d(sidetone_zero_cross), .q(zc_s));

    // Rising-edge detect on the synchronised copies only.
    // The delayed copies reset to the idle low level, so no false edge follows reset.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_word_select_d_r <= 1'b0;
            dac_word_clock_d_r <= 1'b0;
            zc_d_r <= 1'b0;
        end else begin
            adc_word_select_d_r <= adc_word_select_s;
            dac_word_clock_d_r <= dac_word_clock_s;
            zc_d_r <= zc_s;
        end
    end
    assign adc_tick = adc_word_select_s & ~adc_word_select_d_r;
    assign dac_tick = dac_word_clock_s & ~dac_word_clock_d_r;
    assign zc_tick = zc_s & ~zc_d_r;

    // Programmed fields.
    reg [6:0] ast_prog_r;
    reg [5:0] dst_prog_r;
    reg [2:0] click_freq_r;
    reg [3:0] click_len_r;
    reg adc_step_r;
    reg dac_step_r;
    reg click_en_r;
    wire wr_st = reg_wr && (reg_addr == `STKG_ADDR_SIDETONE);
    wire wr_ck = reg_wr && (reg_addr == `STKG_ADDR_CLICK);
    wire burst_done;

    // Register writes; read-only bits in the write data are dropped.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_sidetone_mute <= 1'b1;
            ast_prog_r <= `STKG_AST_GAIN_RST;
            digital_sidetone_mute <= 1'b1;
            dst_prog_r <= `STKG_DST_GAIN_RST;
            click_en_r <= 1'b0;
            click_amplitude <= `STKG_CLK_AMP_RST;
            click_freq_r <= `STKG_CLK_FRQ_RST;
            click_len_r <= `STKG_CLK_LEN_RST;
            adc_step_r <= 1'b0;
            dac_step_r <= 1'b0;
        end else begin
            // Sidetone fields; the flag bit in the write data has no home here.
            if (wr_st) begin
                analog_sidetone_mute <= reg_wdata[`STKG_AST_MUTE_BIT];
                ast_prog_r <= reg_wdata[`STKG_AST_GAIN_HI:`STKG_AST_GAIN_LO];
                digital_sidetone_mute <= reg_wdata[`STKG_DST_MUTE_BIT];
                dst_prog_r <= reg_wdata[`STKG_DST_GAIN_HI:`STKG_DST_GAIN_LO];
            end
            if (wr_ck) begin
                click_amplitude <= reg_wdata[`STKG_CLK_AMP_HI:`STKG_CLK_AMP_LO];
                click_freq_r <= reg_wdata[`STKG_CLK_FRQ_HI:`STKG_CLK_FRQ_LO];
                click_len_r <= reg_wdata[`STKG_CLK_LEN_HI:`STKG_CLK_LEN_LO];
                dac_step_r <= reg_wdata[`STKG_DAC_STEP_BIT];
                // Step bit is read-only while auto gain runs.
                if (!auto_gain_enable) begin
                    adc_step_r <= reg_wdata[`STKG_ADC_STEP_BIT];
                end
            end
            // A fresh start wins over the self-clear in the same cycle.
            // Writing a zero only drops the request; a running burst still ends whole.
            if (wr_ck && reg_wdata[`STKG_CLK_EN_BIT]) begin
                click_en_r <= 1'b1;
            end else if (wr_ck && !reg_wdata[`STKG_CLK_EN_BIT]) begin
                click_en_r <= 1'b0;
            end else if (burst_done) begin
                click_en_r <= 1'b0;
            end
        end
    end

    // Sidetone gains move to the programmed value only on a zero crossing.
    // Out-of-range analog codes are clamped here, so the applied code stops at 12 dB.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_sidetone_gain <= `STKG_AST_GAIN_RST;
            digital_sidetone_gain <= `STKG_DST_GAIN_RST;
        end else if (zc_tick) begin
            analog_sidetone_gain <= ast_sat(ast_prog_r);
            digital_sidetone_gain <= dst_prog_r;
        end
    end
    wire ast_reached = (analog_sidetone_gain == ast_sat(ast_prog_r));

    // Keyclick burst: half-period counter and half-cycle counter.
    reg [HCW-1:0] half_cnt_r;
    reg [5:0] halves_r;
    wire [HCW-1:0] half_len = HALF_TOP[HCW-1:0] << (`STKG_CLK_FRQ_TOP - click_freq_r);
    // The top length code needs 64 halves; the sum wraps to zero, and the
    // compare against total minus one still lands on the 64th half.
    wire [5:0] halves_total = {click_len_r, 2'b00} + 6'h04;
    // A greater-or-equal compare keeps a mid-burst frequency change from leaving
    // the counter above a shorter limit and running on for a million cycles.
    wire half_end = click_active && (half_cnt_r >= half_len - {{(HCW-1){1'b0}}, 1'b1});
    assign burst_done = half_end && (halves_r == halves_total - 6'h01);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            click_active <= 1'b0;
            click_tone <= 1'b0;
            half_cnt_r <= {HCW{1'b0}};
            halves_r <= 6'h00;
        end else if (!click_active) begin
            // Idle: hold the counters clear and arm on a pending request.
            click_tone <= 1'b0;
            half_cnt_r <= {HCW{1'b0}};
            halves_r <= 6'h00;
            click_active <= click_en_r;
        end else if (burst_done) begin
            // 2*(code+1) full periods, counted as half periods.
            click_active <= 1'b0;
            click_tone <= 1'b0;
        end else if (half_end) begin
            half_cnt_r <= {HCW{1'b0}};
            halves_r <= halves_r + 6'h01;
            click_tone <= ~click_tone;
        end else begin
            half_cnt_r <= half_cnt_r + {{(HCW-1){1'b0}}, 1'b1};
        end
    end

    // Soft-stepping followers; auto gain bypasses the programmed target.
    // While auto gain runs the ADC follower holds its last code, so switching
    // back resumes stepping from there instead of jumping to the target.
    wire adc_reached;
    wire dacl_reached;
    wire dacr_reached;
    stkg_stepper #(.W(ADC_GW)) u_step_adc (
        .clk(clk), .rst_n(rst_n), .tick(adc_tick & ~auto_gain_enable),
        .slow(adc_step_r), .target(adc_gain_target),
        .applied(adc_gain_applied), .reached(adc_reached)
    );
    stkg_stepper #(.W(DAC_GW)) u_step_dacl (
        .clk(clk), .rst_n(rst_n), .tick(dac_tick), .slow(dac_step_r),
        .target(dac_left_target), .applied(dac_left_applied), .reached(dacl_reached)
    );
    stkg_stepper #(.W(DAC_GW)) u_step_dacr (
        .clk(clk), .rst_n(rst_n), .tick(dac_tick), .slow(dac_step_r),
        .target(dac_right_target), .applied(dac_right_applied), .reached(dacr_reached)
    );

    // Status flags registered so they read 0 during and just after reset.
    // Forcing the sidetone flag low in the write cycle closes the one-cycle gap
    // before the new programmed code reaches the compare.
    reg ast_flag_r;
    reg dacl_flag_r;
    reg dacr_flag_r;
    reg adc_flag_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ast_flag_r <= 1'b0;
            dacl_flag_r <= 1'b0;
            dacr_flag_r <= 1'b0;
            adc_flag_r <= 1'b0;
        end else begin
            ast_flag_r <= ast_reached && !wr_st;
            dacl_flag_r <= dacl_reached;
            dacr_flag_r <= dacr_reached;
            adc_flag_r <= auto_gain_enable ? agc_saturated : adc_reached;
        end
    end

    // Read mux; unmapped addresses read zero.
    // Flags come from flops, so a read never catches a compare in mid-change.
    always @* begin
        reg_rdata = 16'h0000;
        case (reg_addr)
            `STKG_ADDR_SIDETONE: begin
                reg_rdata[`STKG_AST_MUTE_BIT] = analog_sidetone_mute;
                reg_rdata[`STKG_AST_GAIN_HI:`STKG_AST_GAIN_LO] = ast_prog_r;
                reg_rdata[`STKG_DST_MUTE_BIT] = digital_sidetone_mute;
                reg_rdata[`STKG_DST_GAIN_HI:`STKG_DST_GAIN_LO] = dst_prog_r;
                reg_rdata[`STKG_AST_FLAG_BIT] = ast_flag_r;
            end
            `STKG_ADDR_CLICK: begin
                reg_rdata[`STKG_CLK_EN_BIT] = click_en_r;
                reg_rdata[`STKG_CLK_AMP_HI:`STKG_CLK_AMP_LO] = click_amplitude;
                reg_rdata[`STKG_ADC_STEP_BIT] = auto_gain_enable ? agc_below_noise
                                                                 : adc_step_r;
                reg_rdata[`STKG_CLK_FRQ_HI:`STKG_CLK_FRQ_LO] = click_freq_r;
                reg_rdata[`STKG_CLK_LEN_HI:`STKG_CLK_LEN_LO] = click_len_r;
                reg_rdata[`STKG_DACL_FLAG_BIT] = dacl_flag_r;
                reg_rdata[`STKG_DACR_FLAG_BIT] = dacr_flag_r;
                reg_rdata[`STKG_DAC_STEP_BIT] = dac_step_r;
                reg_rdata[`STKG_ADC_FLAG_BIT] = adc_flag_r;
            end
            default: begin
                reg_rdata = 16'h0000;
            end
        endcase
    end
endmodule // stkg_regs
`default_nettype wire

// File: tb/stkg_regs_monitor.sv
// Concurrent checks on the ports of the sidetone and keyclick register block.
`timescale 1ns/100ps
`default_nettype none
module stkg_regs_monitor #(
    parameter AW = 6,
    parameter ADC_GW = 7,
    parameter DAC_GW = 7
) (
    // Clock, reset and register port.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // Pins, status and outputs.
    input wire logic sidetone_zero_cross,
    input wire logic auto_gain_enable,
    input wire logic agc_saturated,
    input wire logic analog_sidetone_mute,
    input wire logic [6:0] analog_sidetone_gain,
    input wire logic digital_sidetone_mute,
    input wire logic [5:0] digital_sidetone_gain,
    input wire logic [ADC_GW-1:0] adc_gain_applied,
    input wire logic [DAC_GW-1:0] dac_left_applied,
    input wire logic click_active,
    input wire logic [2:0] click_amplitude
);
    localparam logic [AW-1:0] A_ST = AW'(4'h3);
    localparam logic [AW-1:0] A_CK = AW'(4'h4);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic w_st = reg_wr && reg_addr == A_ST;
    wire logic w_ck = reg_wr && reg_addr == A_CK;
    logic [5:0] zc_h;
    // Recent zero-crossing history; the pin passes a synchroniser first.
    always @(posedge clk) begin
        zc_h <= {zc_h[4:0], sidetone_zero_cross};
    end
    chk_amute_write: assert property (w_st |=> analog_sidetone_mute == $past(reg_wdata[15]))
        else $error("analog mute not taken from write");
    chk_dmute_write: assert property (w_st |=> digital_sidetone_mute == $past(reg_wdata[7]))
        else $error("digital mute not taken from write");
    chk_again_zc: assert property (!$stable(analog_sidetone_gain) |-> |zc_h)
        else $error("analog gain moved without zero crossing");
    chk_dgain_zc: assert property (!$stable(digital_sidetone_gain) |-> |zc_h)
        else $error("digital gain moved without zero crossing");
    chk_flag_drop: assert property (w_st && reg_wdata[14:8] != analog_sidetone_gain
        && reg_wdata[14:8] <= 7'h5d |=> !(reg_addr == A_ST && reg_rdata[0]))
        else $error("analog gain flag stayed up after new target");
    chk_click_start: assert property (w_ck && reg_wdata[15] |-> ##2 click_active)
        else $error("keyclick burst did not start");
    chk_amp_write: assert property (w_ck |=> click_amplitude == $past(reg_wdata[14:12]))
        else $error("click amplitude not taken from write");
    chk_dac_step: assert property (!$stable(dac_left_applied) |->
        dac_left_applied - $past(dac_left_applied) inside {DAC_GW'(1), {DAC_GW{1'b1}}})
        else $error("dac gain moved by more than one code");
    chk_adc_frozen: assert property (auto_gain_enable && $past(auto_gain_enable)
        && $past(auto_gain_enable, 2) |-> $stable(adc_gain_applied))
        else $error("adc gain stepped while auto gain on");
    chk_agc_flag: assert property (auto_gain_enable && $past(auto_gain_enable)
        && $stable(agc_saturated) && reg_addr == A_CK |-> reg_rdata[0] == agc_saturated)
        else $error("adc flag does not show saturation");
endmodule // stkg_regs_monitor
bind stkg_regs stkg_regs_monitor #(.AW(AW), .ADC_GW(ADC_GW), .DAC_GW(DAC_GW)) u_mon (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sidetone_zero_cross(sidetone_zero_cross),
    .auto_gain_enable(auto_gain_enable), .agc_saturated(agc_saturated),
    .analog_sidetone_mute(analog_sidetone_mute), .analog_sidetone_gain(analog_sidetone_gain),
    .digital_sidetone_mute(digital_sidetone_mute),
    .digital_sidetone_gain(digital_sidetone_gain), .adc_gain_applied(adc_gain_applied),
    .dac_left_applied(dac_left_applied), .click_active(click_active),
    .click_amplitude(click_amplitude));
`default_nettype wire

// File: tb/stkg_host.sv
// Host model that drives the register port of the block.
`timescale 1ns/100ps
`default_nettype none
module stkg_host (
    // Clock and read data.
    input wire logic clk,
    input wire logic [15:0] reg_rdata,
    // Register port.
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
    end
    // Status bits go out as given; the block must drop them.
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Read data settles combinationally after the address.
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        #1 d = reg_rdata;
    endtask
    // Bounded poll of a status bit before the next gain change.
    task automatic poll(input logic [5:0] a, input int b, output logic v);
        logic [15:0] d;
        v = 1'b0;
        for (int i = 0; i < 4000 && !v; i++) begin
            rd(a, d);
            v = d[b];
        end
    endtask
endmodule // stkg_host
`default_nettype wire

// File: tb/stkg_regs_tb.sv
// Self-checking bench for the sidetone and keyclick register block.
`timescale 1ns/100ps
`default_nettype none
module stkg_regs_tb;
    logic clk, arst_n, ws_a, ws_d, zc, age, bn, sat, wr, am, dm, tone, act, p;
    logic [6:0] tg_a, tg_l, tg_r, ag, aa, la, ra, a0;
    logic [5:0] addr, dg;
    logic [2:0] amp;
    logic [15:0] wd, rdata, d, st, ck;
    int error_cnt = 0;
    int samples_checked = 0;
    int n, t0, t1;
    stkg_host u_host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd));
    stkg_regs dut (.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
        .reg_rdata(rdata), .adc_word_select(ws_a), .dac_word_clock(ws_d),
        .sidetone_zero_cross(zc), .auto_gain_enable(age), .adc_gain_target(tg_a),
        .dac_left_target(tg_l), .dac_right_target(tg_r), .agc_below_noise(bn),
        .agc_saturated(sat), .analog_sidetone_mute(am), .analog_sidetone_gain(ag),
        .digital_sidetone_mute(dm), .digital_sidetone_gain(dg), .adc_gain_applied(aa),
        .dac_left_applied(la), .dac_right_applied(ra), .click_tone(tone),
        .click_active(act), .click_amplitude(amp));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Word clocks run free at different rates, 20 and 24 cycles per period.
    always begin
        repeat (10) @(negedge clk);
        ws_a = ~ws_a;
    end
    always begin
        repeat (12) @(negedge clk);
        ws_d = ~ws_d;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Rule model of the applied analog code: codes past the 12 dB step hold there.
    function automatic logic [6:0] ast_model(input int code);
        return (code > 'h5d) ? 7'h5d : 7'(code);
    endfunction
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // A held pulse long enough to pass the synchroniser.
    task automatic zcp;
        @(negedge clk);
        zc = 1'b1;
        repeat (4) @(negedge clk);
        zc = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    // Raises all targets by four codes and counts word-clock edges to arrival.
    task automatic step(input int sel, input logic slow);
        logic [6:0] t;
        int e;
        e = 0;
        ck[11] = sel == 0 ? slow : 1'b0;
        ck[1] = sel == 1 ? slow : 1'b0;
        u_host.wr(6'h04, ck);
        // Move targets just after a falling word-clock edge, so no tick is in flight.
        p = 1'b0;
        while (!(p && !(sel == 0 ? ws_a : ws_d))) begin
            p = sel == 0 ? ws_a : ws_d;
            @(negedge clk);
        end
        t = (sel == 0 ? aa : la) + 7'h04;
        tg_a = aa + 7'h04;
        tg_l = la + 7'h04;
        tg_r = ra + 7'h04;
        p = sel == 0 ? ws_a : ws_d;
        u_host.rd(6'h04, d);
        chk({15'h0, d[sel == 0 ? 0 : 3]}, 16'h0000);
        for (int i = 0; i < 3000 && (sel == 0 ? aa : la) !== t; i++) begin
            @(negedge clk);
            if ((sel == 0 ? ws_a : ws_d) && !p) e++;
            p = sel == 0 ? ws_a : ws_d;
        end
        chk({9'h0, sel == 0 ? aa : la}, {9'h0, t});
        chk(16'(e >= 4 * (slow + 1) - 1 && e <= 4 * (slow + 1) + 1), 16'h0001);
        u_host.poll(6'h04, sel == 0 ? 0 : 3, p);
        chk({15'h0, p}, 16'h0001);
        u_host.rd(6'h04, d);
        chk({15'h0, d[2] | (sel == 0)}, 16'h0001);
        if (sel == 1) chk({9'h0, ra}, {9'h0, tg_r});
    endtask
    // Watchdog at about twice the expected run of some forty thousand cycles.
    initial begin
        #640_000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        {arst_n, ws_a, ws_d, zc, age, bn, sat} = 7'h00;
        {tg_a, tg_l, tg_r} = 21'h0;
        n = $urandom(32'h04cb);
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        st = 16'hc580;
        ck = 16'h4410;
        u_host.rd(6'h03, d);
        chk(d & 16'hfffe, st);
        chk({am, ag, dm, dg, 1'b0}, st);
        u_host.rd(6'h04, d);
        chk(d & 16'hfff2, ck);
        u_host.rd(6'h05, d);
        chk(d, 16'h0000);
        // Random sidetone settings; a saturating analog code forced on the first pass, the top digital gain bit on the second.
        for (int i = 0; i < 6; i++) begin
            st = 16'($urandom);
            if (i == 0) st[14:8] = 7'h7f;
            if (i == 1) st[6] = 1'b1;
            u_host.wr(6'h03, st);
            st[0] = 1'b0;
            u_host.rd(6'h03, d);
            chk(d & 16'hfffe, st);
            chk({14'h0, am, dm}, {14'h0, st[15], st[7]});
            zcp;
            chk({3'h0, ag, dg}, {3'h0, ast_model(st[14:8]), st[6:1]});
            u_host.rd(6'h03, d);
            chk(d & 16'h0001, 16'h0001);
        end
        // Every amplitude and frequency code, random rate bits, flags written high.
        for (int i = 0; i < 8; i++) begin
            ck = (16'($urandom) & 16'h08f2) | {1'b0, i[2:0], 1'b0, 3'(7 - i), 8'h00};
            u_host.wr(6'h04, ck | 16'h000d);
            u_host.rd(6'h04, d);
            chk(d & 16'hfff2, ck);
            chk({13'h0, amp}, {13'h0, ck[14:12]});
        end
        for (int s = 0; s < 2; s++) begin
            step(0, s[0]);
            step(1, s[0]);
        end
        // Shortest burst at the top frequency: two periods of 15626 cycles.
        ck = 16'h0700;
        u_host.wr(6'h04, 16'h8700);
        n = 0;
        p = tone;
        for (int i = 0; i < 40000; i++) begin
            @(negedge clk);
            if (tone && !p) n++;
            if (tone && !p && n == 1) t0 = i;
            if (tone && !p && n == 2) t1 = i;
            p = tone;
        end
        chk(16'(n), 16'h0002);
        chk(16'(t1 - t0 >= 15623 && t1 - t0 <= 15627), 16'h0001);
        u_host.rd(6'h04, d);
        chk({14'h0, d[15], act}, 16'h0000);
        // Auto gain owns the step bit and the adc flag; writes to bit 11 refused.
        age = 1'b1;
        a0 = aa;
        for (int i = 0; i < 4; i++) begin
            {bn, sat} = 2'($urandom);
            tg_a = 7'($urandom);
            u_host.wr(6'h04, {4'h0, ~bn, 11'h000});
            repeat (3) @(negedge clk);
            u_host.rd(6'h04, d);
            chk({14'h0, d[11], d[0]}, {14'h0, bn, sat});
            chk({9'h0, aa}, {9'h0, a0});
        end
        print_verdict;
    end
endmodule // stkg_regs_tb
`default_nettype wire
